// ---- eipu_pkg.sv ----
// eipu_pkg: constants and types of the external pin interrupt unit
// assumes an AXI4-Lite slave with 32-bit data, one aclk domain
package eipu_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] EIPU_IDX_ENABLE   = 10'h03D;
  localparam logic [9:0] EIPU_IDX_SENSE    = 10'h069;
  localparam logic [9:0] EIPU_IDX_FLAGS    = 10'h03C;
  localparam logic [9:0] EIPU_IDX_PC_EN    = 10'h068;
  localparam logic [9:0] EIPU_IDX_PC_FLAGS = 10'h03B;
  localparam logic [9:0] EIPU_IDX_MSK_LOW  = 10'h06B;
  localparam logic [9:0] EIPU_IDX_MSK_MID  = 10'h06C;
  localparam logic [9:0] EIPU_IDX_MSK_HIGH = 10'h06D;

  localparam int EIPU_ADDR_W = 12;
  localparam int EIPU_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // field layouts and encodings
  // ----------------------------------------------------------------
  localparam int EIPU_SENSE_ONE_LSB  = 2;
  localparam int EIPU_SENSE_ZERO_LSB = 0;
  localparam logic [1:0] EIPU_SENSE_LOW     = 2'h0;
  localparam logic [1:0] EIPU_SENSE_ANY     = 2'h1;
  localparam logic [1:0] EIPU_SENSE_FALLING = 2'h2;
  localparam logic [1:0] EIPU_SENSE_RISING  = 2'h3;

  localparam logic [1:0] EIPU_RESP_OKAY   = 2'h0;
  localparam logic [1:0] EIPU_RESP_SLVERR = 2'h2;

  localparam int EIPU_NUM_PINS = 2;
  localparam int EIPU_NUM_PC   = 24;
  localparam int EIPU_NUM_VEC  = 5;

  // vector request slots
  localparam int EIPU_VEC_PIN_ZERO = 0;
  localparam int EIPU_VEC_PIN_ONE  = 1;
  localparam int EIPU_VEC_PC_LOW   = 2;
  localparam int EIPU_VEC_PC_MID   = 3;
  localparam int EIPU_VEC_PC_HIGH  = 4;

  // ----------------------------------------------------------------
  // state of the unit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]             sense;
    logic [1:0]             en;
    logic [1:0]             flg;
    logic [2:0]             pc_en;
    logic [2:0]             pc_flg;
    logic [7:0]             msk_low;
    logic [6:0]             msk_mid;
    logic [7:0]             msk_high;
    logic [1:0]             pin_smp;
    logic [1:0]             pin_prev;
    logic [23:0]            pc_smp;
    logic [23:0]            pc_prev;
    logic                   aw_held;
    logic                   w_held;
    logic [EIPU_ADDR_W-1:0] awaddr;
    logic [7:0]             wdata;
    logic                   wstrb0;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [7:0]             rdata;
    logic [4:0]             vec_req;
    logic                   irq;
    logic                   wake;
  } eipu_state_t;

  localparam eipu_state_t EIPU_STATE_RST = '0;

endpackage

// ---- eipu_top.sv ----
// eipu_top: external pin interrupt unit with AXI4-Lite registers
// assumes pins synchronous to aclk; cpu vectoring acks one slot per pulse
`timescale 1ns/100ps
module eipu_top
  import eipu_pkg::*;
(
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi write address
  input  wire logic [eipu_pkg::EIPU_ADDR_W-1:0] awaddr,
  input  wire logic                         awvalid,
  output logic                              awready,
  // axi write data
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  // axi write response
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  // axi read address
  input  wire logic [eipu_pkg::EIPU_ADDR_W-1:0] araddr,
  input  wire logic                         arvalid,
  output logic                              arready,
  // axi read data
  output logic [31:0]                       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  // pins
  input  wire logic                         ext_irq_pin_zero,
  input  wire logic                         ext_irq_pin_one,
  input  wire logic [eipu_pkg::EIPU_NUM_PC-1:0] pin_change_inputs,
  // cpu side
  input  wire logic                         global_irq_enable,
  input  wire logic                         io_clk_run,
  input  wire logic [eipu_pkg::EIPU_NUM_VEC-1:0] vector_ack,
  output logic [eipu_pkg::EIPU_NUM_VEC-1:0] vector_req,
  output logic                              irq,
  output logic                              wake_request
);

  import eipu_pkg::*;

  eipu_state_t st;
  eipu_state_t nx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic cur,
                                    input logic prev);
    logic hit;
    hit = 1'b0;
    case (mode)
      EIPU_SENSE_ANY:     hit = cur ^ prev;
      EIPU_SENSE_FALLING: hit = prev & ~cur;
      EIPU_SENSE_RISING:  hit = ~prev & cur;
      default:            hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [9:0] idx_of(input logic [EIPU_ADDR_W-1:0] a);
    return a[EIPU_ADDR_W-1:EIPU_IDX_LSB];
  endfunction

  function automatic logic [1:0] pin_mode(input logic [3:0] sense,
                                          input int pin);
    logic [1:0] m;
    m = (pin == EIPU_VEC_PIN_ONE) ? sense[EIPU_SENSE_ONE_LSB +: 2]
                                  : sense[EIPU_SENSE_ZERO_LSB +: 2];
    return m;
  endfunction

  function automatic logic is_mapped(input logic [9:0] idx);
    return (idx == EIPU_IDX_ENABLE)  || (idx == EIPU_IDX_SENSE)
        || (idx == EIPU_IDX_FLAGS)   || (idx == EIPU_IDX_PC_EN)
        || (idx == EIPU_IDX_PC_FLAGS) || (idx == EIPU_IDX_MSK_LOW)
        || (idx == EIPU_IDX_MSK_MID) || (idx == EIPU_IDX_MSK_HIGH);
  endfunction

  function automatic logic [1:0] resp_of(input logic [9:0] idx);
    return is_mapped(idx) ? EIPU_RESP_OKAY : EIPU_RESP_SLVERR;
  endfunction

  // level mode asks while the pin is low
  function automatic logic lvl_hit(input logic [1:0] mode,
                                   input logic       pin);
    return (mode == EIPU_SENSE_LOW) && !pin;
  endfunction

  // change hits per group; bit 15 belongs to no group
  function automatic logic [2:0] grp_hits(input logic [23:0] chg,
                                          input logic [7:0]  m_low,
                                          input logic [6:0]  m_mid,
                                          input logic [7:0]  m_high);
    logic [2:0] h;
    h    = 3'h0;
    h[0] = |(chg[7:0] & m_low);
    h[1] = |(chg[14:8] & m_mid);
    h[2] = |(chg[23:16] & m_high);
    return h;
  endfunction

  // sticky flags: an event in the cycle of its clear wins
  function automatic logic [2:0] sticky(input logic [2:0] flags,
                                        input logic [2:0] clr,
                                        input logic [2:0] set);
    return (flags & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_val(input eipu_state_t s,
                                        input logic [9:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      EIPU_IDX_ENABLE:   v = {6'h00, s.en};
      EIPU_IDX_SENSE:    v = {4'h0, s.sense};
      EIPU_IDX_FLAGS:    v = {6'h00, s.flg};
      EIPU_IDX_PC_EN:    v = {5'h00, s.pc_en};
      EIPU_IDX_PC_FLAGS: v = {5'h00, s.pc_flg};
      EIPU_IDX_MSK_LOW:  v = s.msk_low;
      EIPU_IDX_MSK_MID:  v = {1'b0, s.msk_mid};
      EIPU_IDX_MSK_HIGH: v = s.msk_high;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0]  pin_ev;
    logic [1:0]  lvl_mode;
    logic [1:0]  lvl_low;
    logic [1:0]  lvl_raw;
    logic [1:0]  clr_flg;
    logic [2:0]  clr_pc;
    logic [2:0]  pc_ev;
    logic [23:0] pc_chg;
    logic [23:0] pc_raw;
    logic [9:0]  widx;
    logic        wr_go;
    pin_ev   = 2'h0;
    lvl_mode = 2'h0;
    lvl_low  = 2'h0;
    lvl_raw  = 2'h0;
    clr_flg  = vector_ack[EIPU_VEC_PIN_ONE:EIPU_VEC_PIN_ZERO];
    clr_pc   = vector_ack[EIPU_VEC_PC_HIGH:EIPU_VEC_PC_LOW];
    pc_ev    = 3'h0;
    pc_chg   = 24'h000000;
    pc_raw   = 24'h000000;
    widx     = idx_of(st.awaddr);
    wr_go    = st.aw_held && st.w_held && !st.bvalid;
    nx       = st;

    // --------------------------------------------------------------
    // pin sampling before any edge test
    // --------------------------------------------------------------
    // sampling never stops, so a restarted io clock sees no stale edge
    nx.pin_smp = {ext_irq_pin_one, ext_irq_pin_zero};
    nx.pin_prev = st.pin_smp;
    nx.pc_smp = pin_change_inputs;
    nx.pc_prev = st.pc_smp;

    // --------------------------------------------------------------
    // write address and data, taken in either order
    // --------------------------------------------------------------
    if (awvalid && st.awready) begin
      nx.aw_held = 1'b1;
      nx.awaddr = awaddr;
    end
    if (wvalid && st.wready) begin
      nx.w_held = 1'b1;
      nx.wdata = wdata[7:0];
      nx.wstrb0 = wstrb[0];
    end
    if (st.bvalid && bready) begin
      nx.bvalid = 1'b0;
    end

    // --------------------------------------------------------------
    // register write, one cycle after both are held
    // --------------------------------------------------------------
    if (wr_go) begin
      nx.aw_held = 1'b0;
      nx.w_held = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = resp_of(widx);
      if (st.wstrb0) begin
        case (widx)
          EIPU_IDX_ENABLE:   nx.en = st.wdata[1:0];
          EIPU_IDX_SENSE:    nx.sense = st.wdata[3:0];
          EIPU_IDX_FLAGS:    clr_flg = clr_flg | st.wdata[1:0];
          EIPU_IDX_PC_EN:    nx.pc_en = st.wdata[2:0];
          EIPU_IDX_PC_FLAGS: clr_pc = clr_pc | st.wdata[2:0];
          EIPU_IDX_MSK_LOW:  nx.msk_low = st.wdata;
          EIPU_IDX_MSK_MID:  nx.msk_mid = st.wdata[6:0];
          EIPU_IDX_MSK_HIGH: nx.msk_high = st.wdata;
          default:           nx.bresp = EIPU_RESP_SLVERR;
        endcase
      end
    end
    nx.awready = !nx.aw_held && !nx.bvalid;
    nx.wready = !nx.w_held && !nx.bvalid;

    // --------------------------------------------------------------
    // read channel
    // --------------------------------------------------------------
    if (st.rvalid && rready) begin
      nx.rvalid = 1'b0;
    end
    if (arvalid && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rdata = rd_val(st, idx_of(araddr));
      nx.rresp = resp_of(idx_of(araddr));
    end
    nx.arready = !nx.rvalid;

    // --------------------------------------------------------------
    // dedicated pins: edges only while the io clock runs
    // --------------------------------------------------------------
    for (int i = 0; i < EIPU_NUM_PINS; i++) begin
      lvl_mode[i] = pin_mode(st.sense, i) == EIPU_SENSE_LOW;
      lvl_low[i] = lvl_mode[i] && !st.pin_smp[i];
      lvl_raw[i] = lvl_hit(pin_mode(st.sense, i), nx.pin_smp[i]);
      pin_ev[i] = io_clk_run
                && edge_hit(pin_mode(st.sense, i), st.pin_smp[i],
                            st.pin_prev[i]);
    end

    // --------------------------------------------------------------
    // flags: a new event wins over an ack or write clear, not over a switch to level mode
    // --------------------------------------------------------------
    nx.flg = 2'(sticky({1'b0, st.flg}, {1'b0, clr_flg}, {1'b0, pin_ev}));
    for (int i = 0; i < EIPU_NUM_PINS; i++) begin
      if (pin_mode(nx.sense, i) == EIPU_SENSE_LOW) begin
        nx.flg[i] = 1'b0;
      end
    end

    // --------------------------------------------------------------
    // pin-change groups, no io clock needed
    // --------------------------------------------------------------
    pc_chg = st.pc_smp ^ st.pc_prev;
    pc_ev = grp_hits(pc_chg, st.msk_low, st.msk_mid, st.msk_high);
    nx.pc_flg = sticky(st.pc_flg, clr_pc, pc_ev);

    // --------------------------------------------------------------
    // requests toward the cpu vectoring
    // --------------------------------------------------------------
    for (int i = 0; i < EIPU_NUM_PINS; i++) begin
      nx.vec_req[i] = global_irq_enable && nx.en[i]
                    && (lvl_low[i] || nx.flg[i]);
    end
    for (int g = 0; g < 3; g++) begin
      nx.vec_req[EIPU_VEC_PC_LOW + g] = global_irq_enable
                                      && nx.pc_en[g] && nx.pc_flg[g];
    end
    nx.irq = |(nx.flg & nx.en) || |(lvl_low & nx.en)
          || |(nx.pc_flg & nx.pc_en);

    // --------------------------------------------------------------
    // wake path looks at raw pins, not the io clock
    // --------------------------------------------------------------
    // outputs must be flops, so wake trails the raw pin by one clock
    pc_raw = pin_change_inputs ^ st.pc_smp;
    nx.wake = |(grp_hits(pc_raw, st.msk_low, st.msk_mid, st.msk_high) & st.pc_en)
           || |(lvl_raw & st.en);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= EIPU_STATE_RST;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready      = st.awready;
  assign wready       = st.wready;
  assign bvalid       = st.bvalid;
  assign bresp        = st.bresp;
  assign arready      = st.arready;
  assign rvalid       = st.rvalid;
  assign rresp        = st.rresp;
  assign rdata        = {24'h000000, st.rdata};
  assign vector_req   = st.vec_req;
  assign irq          = st.irq;
  assign wake_request = st.wake;

endmodule // eipu_top

// ---- eipu_props.sv ----
// eipu_props: port checks of eipu_top
// assumes one aclk domain, sync active-low reset
`timescale 1ns/100ps
module eipu_props
  import eipu_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // interrupt side
  input wire logic        ext_irq_pin_one,
  input wire logic        global_irq_enable,
  input wire logic [4:0]  vector_ack,
  input wire logic [4:0]  vector_req,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------
  // step sequences
  // --------------
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence pin_one_quiet;
    ext_irq_pin_one && $past(ext_irq_pin_one) && $past(ext_irq_pin_one, 2);
  endsequence
  gie_gate_a: assert property (!$past(global_irq_enable) |-> vector_req == 5'h00)
    else $error("request without global enable");
  req_irq_a: assert property (vector_req != 5'h00 |-> irq)
    else $error("request without irq");
  ack_clear_a: assert property (
    vector_ack[1] ##0 pin_one_quiet ##1 ext_irq_pin_one |=> !vector_req[1])
    else $error("request stays after ack");
  wr_resp_a: assert property (wr_take |=> !bvalid ##1 bvalid)
    else $error("write response late or early");
  wr_busy_a: assert property (wr_take |=> (!awready && !wready) [*2])
    else $error("write readies back too early");
  b_done_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  rd_resp_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data late");
  rd_done_a: assert property (rvalid && rready |=> !rvalid)
    else $error("read data not released");
  rd_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule // eipu_props

bind eipu_top eipu_props u_props (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata, .ext_irq_pin_one,
  .global_irq_enable, .vector_ack, .vector_req, .irq);

// ---- eipu_cpu_model.sv ----
// eipu_cpu_model: cpu vectoring, acks the lowest requested slot
// assumes level vector_req from eipu_top on aclk
`timescale 1ns/100ps
module eipu_cpu_model
  import eipu_pkg::*;
(
  // clock and reset
  input wire logic                              aclk,
  input wire logic                              aresetn,
  // bench control
  input wire logic                              serve,
  input wire logic [3:0]                        delay,
  // vectoring
  input wire logic [eipu_pkg::EIPU_NUM_VEC-1:0] vector_req,
  output logic     [eipu_pkg::EIPU_NUM_VEC-1:0] vector_ack
);
  logic [3:0] wait_cnt;
  always_ff @(posedge aclk) begin
    vector_ack <= '0;
    if (!aresetn || !serve || vector_req == '0 || vector_ack != '0) begin
      wait_cnt <= '0;
    end else if (wait_cnt < delay) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      vector_ack <= vector_req & (~vector_req + 5'h01);
      wait_cnt <= '0;
    end
  end
endmodule // eipu_cpu_model

// ---- testbench.sv ----
// testbench: registers, pins and pin-change groups of eipu_top
// assumes eipu_cpu_model as vectoring partner, eipu_props bound in
`timescale 1ns/100ps
module testbench;
  import eipu_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, gie;
  logic        awready, wready, bvalid, arready, rvalid, irq, wake_request;
  logic        pin0, pin1, serve, io_clk_run;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, ack_delay;
  logic [1:0]  bresp, rresp;
  logic [23:0] pc;
  logic [4:0]  vector_ack, vector_req;
  int          n_errors, n_tests;
  eipu_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1),
    .pin_change_inputs(pc), .global_irq_enable(gie), .io_clk_run, .vector_ack,
    .vector_req, .irq, .wake_request);
  eipu_cpu_model u_cpu (.aclk, .aresetn, .serve, .delay(ack_delay), .vector_req,
    .vector_ack);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic set_pin(input int p, input logic v);
    @(posedge aclk);
    if (p == 0) pin0 <= v;
    else pin1 <= v;
  endtask
  task automatic axi(input bit wr, input logic [9:0] idx, input logic [7:0] d,
                     output logic [1:0] resp, output logic [7:0] q);
    logic a, w;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    araddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= {3{wr}};
    {arvalid, rready} <= {2{!wr}};
    for (int k = 0; k < 40; k++) begin
      @(negedge aclk);
      a = (awvalid && awready) || (arvalid && arready);
      w = wvalid && wready;
      resp = wr ? bresp : rresp;
      q = rdata[7:0];
      @(posedge aclk);
      if (a) {awvalid, arvalid} <= 2'h0;
      if (w) wvalid <= 1'b0;
      if ((wr && bvalid) || (!wr && rvalid)) begin
        {bready, rready} <= 2'h0;
        return;
      end
    end
    n_errors++;
    final_report;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [1:0] r;
    logic [7:0] q;
    axi(1'b1, idx, d, r, q);
    chk("write resp", {30'h0, r}, {30'h0, EIPU_RESP_OKAY});
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    logic [1:0] r;
    logic [7:0] q;
    axi(1'b0, idx, 8'h00, r, q);
    chk("read", {22'h0, r, q}, {22'h0, EIPU_RESP_OKAY, e});
  endtask
  task automatic t_regs;
    logic [1:0] r;
    logic [7:0] q;
    rd(EIPU_IDX_SENSE, 8'h00);
    wr(EIPU_IDX_SENSE, 8'hFF);
    rd(EIPU_IDX_SENSE, 8'h0F);
    wr(EIPU_IDX_ENABLE, 8'hFF);
    rd(EIPU_IDX_ENABLE, 8'h03);
    wr(EIPU_IDX_MSK_MID, 8'hFF);
    rd(EIPU_IDX_MSK_MID, 8'h7F);
    axi(1'b0, 10'h000, 8'h00, r, q);
    chk("unmapped", {22'h0, r, q}, {22'h0, EIPU_RESP_SLVERR, 8'h00});
    axi(1'b1, 10'h000, 8'hFF, r, q);
    chk("unmapped wr", {30'h0, r}, {30'h0, EIPU_RESP_SLVERR});
    wstrb <= 4'h0;
    wr(EIPU_IDX_MSK_MID, 8'h00);
    wstrb <= 4'hF;
    rd(EIPU_IDX_MSK_MID, 8'h7F);
    wr(EIPU_IDX_ENABLE, 8'h00);
  endtask
  task automatic t_edges;
    logic [7:0] fb;
    @(posedge aclk);
    gie <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      fb = 8'h01 << p;
      for (int m = 1; m < 4; m++) begin
        wr(EIPU_IDX_SENSE, 8'(m) << (2 * p));
        set_pin(p, 1'b0);
        tick(4);
        chk("gated req", {27'h0, vector_req}, 32'h0);
        rd(EIPU_IDX_FLAGS, (m != 3) ? fb : 8'h00);
        wr(EIPU_IDX_FLAGS, fb);
        set_pin(p, 1'b1);
        tick(4);
        rd(EIPU_IDX_FLAGS, (m != 2) ? fb : 8'h00);
        wr(EIPU_IDX_FLAGS, fb);
        rd(EIPU_IDX_FLAGS, 8'h00);
      end
    end
  endtask
  task automatic t_level;
    wr(EIPU_IDX_ENABLE, 8'h03);
    @(posedge aclk);
    io_clk_run <= 1'b0;
    wr(EIPU_IDX_SENSE, 8'h08);
    set_pin(1, 1'b0);
    set_pin(0, 1'b0);
    tick(3);
    @(negedge aclk);
    chk("level req", {27'h0, vector_req}, 32'h1);
    chk("wake", {31'h0, wake_request}, 32'h1);
    tick(20);
    rd(EIPU_IDX_FLAGS, 8'h00);
    @(posedge aclk);
    gie <= 1'b0;
    io_clk_run <= 1'b1;
    tick(3);
    @(negedge aclk);
    chk("level gated", {26'h0, vector_req, irq}, 32'h1);
    set_pin(0, 1'b1);
    set_pin(1, 1'b1);
    gie <= 1'b1;
    tick(3);
    @(negedge aclk);
    chk("level gone", {27'h0, vector_req}, 32'h0);
  endtask
  task automatic t_serve;
    int k;
    wr(EIPU_IDX_SENSE, 8'h0C);
    set_pin(1, 1'b0);
    serve <= 1'b1;
    ack_delay <= 4'h6;
    set_pin(1, 1'b1);
    for (k = 0; k < 30 && vector_ack === 5'h00; k++) @(negedge aclk);
    if (k == 30) begin
      n_errors++;
      final_report;
    end
    chk("ack slot", {27'h0, vector_ack}, 32'h2);
    tick(3);
    @(negedge aclk);
    chk("req after ack", {27'h0, vector_req}, 32'h0);
    rd(EIPU_IDX_FLAGS, 8'h00);
    serve <= 1'b0;
  endtask
  task automatic t_pc;
    int pins[4] = '{1, 0, 8, 23};
    logic [7:0] e[4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    wr(EIPU_IDX_PC_EN, 8'h07);
    wr(EIPU_IDX_MSK_LOW, 8'h01);
    wr(EIPU_IDX_MSK_MID, 8'h01);
    wr(EIPU_IDX_MSK_HIGH, 8'h80);
    rd(EIPU_IDX_PC_EN, 8'h07);
    rd(EIPU_IDX_MSK_HIGH, 8'h80);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      pc[pins[i]] <= ~pc[pins[i]];
      @(posedge aclk);
      @(negedge aclk);
      chk("pc wake", {31'h0, wake_request}, {31'h0, e[i] != 8'h00});
      tick(3);
      @(negedge aclk);
      chk("pc req", {27'h0, vector_req}, {22'h0, e[i], 2'h0});
      rd(EIPU_IDX_PC_FLAGS, e[i]);
      wr(EIPU_IDX_PC_FLAGS, e[i]);
    end
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, gie, serve} = 7'h00;
    {awaddr, araddr, wdata, pc} = 80'h0;
    {pin0, pin1, io_clk_run} = 3'h7;
    wstrb = 4'hF;
    ack_delay = 4'h1;
    tick(8);
    aresetn <= 1'b1;
    tick(2);
    t_regs;
    t_edges;
    t_level;
    t_serve;
    t_pc;
    final_report;
  end
endmodule // testbench
